// File: verilog/strap_latch_consts.vh
// constants for the strap latch and boot select block
// Function
// RULE_01 - latch three straps in reset, hold
// RULE_02 - sample on every system reset source
// RULE_03 - software reads latched straps via register
// RULE_04 - boot-select strap pulled up, floating reads 1
// RULE_05 - after reset straps become function pins
// RULE_06 - boot-select 1 flash, else print 1 download; the code selects neither when the auxiliary strap is 0
// RULE_07 - both straps 0 is an invalid combination
// RULE_08 - policy 0 prints always, 3 never
// RULE_09 - policy 1 prints on 0, 2 on 1
// RULE_10 - outside party drives straps during power-on
// RULE_11 - decoded outputs come only from held latches
`ifndef STRAP_LATCH_CONSTS_VH
`define STRAP_LATCH_CONSTS_VH

`define ADDR_STRAP_STATUS 4'h0
`define ADDR_BOOT_STATUS 4'h4
`define ADDR_PIN_CTRL 4'h8
`define ADDR_PIN_INPUT 4'hC

`define STRAP_AUX_BIT 0
`define STRAP_PRINT_BIT 1
`define STRAP_BOOT_BIT 2

`define BOOT_FLASH_BIT 0
`define BOOT_DOWNLOAD_BIT 1
`define BOOT_INVALID_BIT 2
`define BOOT_PRINT_EN_BIT 3
`define BOOT_POLICY_LSB 4
`define BOOT_SAMPLED_BIT 6

`define STRAP_RESET_VALUE 3'h7
`define PIN_CTRL_RESET_VALUE 6'h00

`define POLICY_ALWAYS 2'h0
`define POLICY_ON_LOW 2'h1
`define POLICY_ON_HIGH 2'h2
`define POLICY_NEVER 2'h3

`endif

// File: verilog/strap_latch_boot_select.v
// strap latch, boot mode decode and register port for the three strap pins
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "strap_latch_consts.vh"

module strap_latch_boot_select #(
   parameter ADDR_WIDTH = 4,
   parameter DATA_WIDTH = 32
) (
   input wire clk,
   input wire rst_n,
   // system reset sources, active high levels
   input wire porReset,
   input wire lpWdtReset,
   input wire brownoutReset,
   input wire anaWdtReset,
   input wire glitchReset,
   // one-time-programmable print policy field
   input wire [1:0] printPolicy,
   // strap pins, split into input, output and active-low enable
   input wire strapPinAuxIn,
   input wire strapPinPrintIn,
   input wire strapPinBootSelectIn,
   // high when something outside actually drives the boot-select pin
   input wire strapPinBootSelectDriven,
   output reg strapPinAuxOut,
   output reg strapPinPrintOut,
   output reg strapPinBootSelectOut,
   output reg strapPinAuxOeN,
   output reg strapPinPrintOeN,
   output reg strapPinBootSelectOeN,
   output reg bootSelectPullUp,
   // decoded boot selection
   output reg bootFlash,
   output reg bootDownload,
   output reg bootInvalid,
   output reg printEnable,
   // register port
   input wire [ADDR_WIDTH-1:0] addr,
   input wire [DATA_WIDTH-1:0] wrData,
   input wire wrStrobe,
   input wire rdStrobe,
   output reg [DATA_WIDTH-1:0] rdData
);

   ////////////////////////////////////////////////////////////////////////////

   wire sysReset;
   wire [2:0] pinLevel;
   wire [2:0] strapNext;
   wire flashNext;
   wire downloadNext;
   wire invalidNext;
   reg printNext;
   reg [2:0] strap_reg;
   reg [1:0] policy_reg;
   reg sampled_reg;
   reg [5:0] pinCtrl_reg;
   reg [2:0] pinIn_reg;

   assign sysReset = porReset | lpWdtReset | brownoutReset | anaWdtReset | glitchReset; // [RULE_02]

   // a floating boot-select pin is lifted by the internal pull-up
   assign pinLevel[`STRAP_AUX_BIT] = strapPinAuxIn;
   assign pinLevel[`STRAP_PRINT_BIT] = strapPinPrintIn;
   assign pinLevel[`STRAP_BOOT_BIT] = strapPinBootSelectIn | ~strapPinBootSelectDriven; // [RULE_04]

   // straps follow the pins only while a system reset is held
   assign strapNext = sysReset ? pinLevel : strap_reg; // [RULE_01]

   ////////////////////////////////////////////////////////////////////////////
   // latches; cleared only by power-down (rst_n)

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_reg <= `STRAP_RESET_VALUE;
         policy_reg <= `POLICY_ALWAYS;
         sampled_reg <= 1'b0;
      end else begin
         strap_reg <= strapNext; // [RULE_01]
         if (sysReset) begin
            policy_reg <= printPolicy;
            sampled_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode from the held values only, so later pin traffic cannot disturb it

   assign flashNext = strap_reg[`STRAP_BOOT_BIT]; // [RULE_06] [RULE_11]
   assign downloadNext = ~strap_reg[`STRAP_BOOT_BIT] & strap_reg[`STRAP_PRINT_BIT]; // [RULE_06]
   // both straps low, or the auxiliary strap low, is not a boot mode
   assign invalidNext = (~strap_reg[`STRAP_BOOT_BIT] & ~strap_reg[`STRAP_PRINT_BIT])
                        | ~strap_reg[`STRAP_AUX_BIT]; // [RULE_07]

   always @* begin
      printNext = 1'b1;
      case (policy_reg)
         `POLICY_ALWAYS: printNext = 1'b1; // [RULE_08]
         `POLICY_ON_LOW: printNext = ~strap_reg[`STRAP_PRINT_BIT]; // [RULE_09]
         `POLICY_ON_HIGH: printNext = strap_reg[`STRAP_PRINT_BIT]; // [RULE_09]
         default: printNext = 1'b0; // [RULE_08]
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootFlash <= 1'b1;
         bootDownload <= 1'b0;
         bootInvalid <= 1'b0;
         printEnable <= 1'b1;
      end else begin
         bootFlash <= flashNext & ~invalidNext; // [RULE_11]
         bootDownload <= downloadNext & ~invalidNext; // [RULE_11]
         bootInvalid <= invalidNext; // [RULE_07]
         printEnable <= printNext; // [RULE_11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // function pins: released during reset, driven from the control register after

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapPinAuxOut <= 1'b0;
         strapPinPrintOut <= 1'b0;
         strapPinBootSelectOut <= 1'b0;
         strapPinAuxOeN <= 1'b1;
         strapPinPrintOeN <= 1'b1;
         strapPinBootSelectOeN <= 1'b1;
         bootSelectPullUp <= 1'b1;
         pinIn_reg <= 3'h0;
      end else begin
         // pin drive is held off from the second edge of a system reset on, so the first strap sample can still see it
         strapPinAuxOut <= pinCtrl_reg[`STRAP_AUX_BIT]; // [RULE_05]
         strapPinPrintOut <= pinCtrl_reg[`STRAP_PRINT_BIT];
         strapPinBootSelectOut <= pinCtrl_reg[`STRAP_BOOT_BIT];
         strapPinAuxOeN <= sysReset | ~pinCtrl_reg[3 + `STRAP_AUX_BIT]; // [RULE_05]
         strapPinPrintOeN <= sysReset | ~pinCtrl_reg[3 + `STRAP_PRINT_BIT];
         strapPinBootSelectOeN <= sysReset | ~pinCtrl_reg[3 + `STRAP_BOOT_BIT];
         bootSelectPullUp <= sysReset | ~pinCtrl_reg[3 + `STRAP_BOOT_BIT]; // [RULE_04]
         pinIn_reg <= {strapPinBootSelectIn, strapPinPrintIn, strapPinAuxIn}; // [RULE_05]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port; a system reset also restores the pin control register

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinCtrl_reg <= `PIN_CTRL_RESET_VALUE;
      end else if (sysReset) begin
         pinCtrl_reg <= `PIN_CTRL_RESET_VALUE;
      end else if (wrStrobe && addr == `ADDR_PIN_CTRL) begin
         pinCtrl_reg <= wrData[5:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= {DATA_WIDTH{1'b0}};
      end else if (rdStrobe) begin
         if (addr == `ADDR_STRAP_STATUS) begin
            rdData <= {{(DATA_WIDTH-3){1'b0}}, strap_reg}; // [RULE_03]
         end else if (addr == `ADDR_BOOT_STATUS) begin
            rdData <= {{(DATA_WIDTH-7){1'b0}}, sampled_reg, policy_reg, printEnable,
                       bootInvalid, bootDownload, bootFlash};
         end else if (addr == `ADDR_PIN_CTRL) begin
            rdData <= {{(DATA_WIDTH-6){1'b0}}, pinCtrl_reg};
         end else if (addr == `ADDR_PIN_INPUT) begin
            rdData <= {{(DATA_WIDTH-3){1'b0}}, pinIn_reg};
         end else begin
            rdData <= {DATA_WIDTH{1'b0}};
         end
      end else begin
         rdData <= {DATA_WIDTH{1'b0}};
      end
   end

endmodule // strap_latch_boot_select

// File: verification/strap_board_model.sv
// board side of the straps: pull resistors or host gpio
`timescale 1ns/1ps
module strap_board_model (
   input wire clk, bootDrv, strapPinAuxOut, strapPinPrintOut, strapPinBootSelectOut,
   input wire strapPinAuxOeN, strapPinPrintOeN, strapPinBootSelectOeN, bootSelectPullUp,
   input wire [2:0] lvl,
   output wire strapPinAuxIn, strapPinPrintIn, strapPinBootSelectIn, strapPinBootSelectDriven
);
   reg tog = 1'b0;
   always @(posedge clk) tog <= ~tog;
   // board levels show whenever the device is not driving
   assign strapPinAuxIn = strapPinAuxOeN ? lvl[0] : strapPinAuxOut;
   assign strapPinPrintIn = strapPinPrintOeN ? lvl[1] : strapPinPrintOut;
   // a released pin with no pull-up wanders, so it never passes for a level
   assign strapPinBootSelectIn = !strapPinBootSelectOeN ? strapPinBootSelectOut :
      bootDrv ? lvl[2] : bootSelectPullUp | tog;
   assign strapPinBootSelectDriven = bootDrv;
endmodule // strap_board_model

// File: verification/strap_latch_boot_select_asserts.sv
// checker on the strap latch ports
`timescale 1ns/1ps
module strap_latch_boot_select_asserts (
   input wire clk, rst_n, porReset, lpWdtReset, brownoutReset, anaWdtReset, glitchReset,
   input wire strapPinAuxIn, strapPinPrintIn, strapPinBootSelectIn, strapPinBootSelectDriven,
   input wire strapPinAuxOeN, strapPinPrintOeN, strapPinBootSelectOeN, bootSelectPullUp,
   input wire bootFlash, bootDownload, bootInvalid, printEnable, rdStrobe,
   input wire [1:0] printPolicy,
   input wire [3:0] addr,
   input wire [31:0] rdData
);
   wire anyRst = porReset | lpWdtReset | brownoutReset | anaWdtReset | glitchReset;
   wire bootS = strapPinBootSelectIn | ~strapPinBootSelectDriven;
   reg [1:0] hist;
   reg [4:0] snap;
   // quiet: two edges with no sampling, so outputs must show the last sample
   wire quiet = hist == 2'b00;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= 2'b00;
         snap <= 5'h07;
      end else begin
         hist <= {hist[0], anyRst};
         if (anyRst) snap <= {printPolicy, bootS, strapPinPrintIn, strapPinAuxIn};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_fl; quiet |-> bootFlash == (snap[0] & snap[2]); endproperty
   property p_dl; quiet |-> bootDownload == (snap[0] & ~snap[2] & snap[1]); endproperty
   property p_inv; quiet |-> bootInvalid == ~(snap[0] & (snap[2] | snap[1])); endproperty
   property p_pe; quiet |-> printEnable == (snap[4:3] == 2'h0 ||
      snap[4:3] == 2'h1 && !snap[1] || snap[4:3] == 2'h2 && snap[1]); endproperty
   property p_hold; quiet |=> $stable({bootFlash, bootDownload, bootInvalid, printEnable});
   endproperty
   property p_oe; anyRst [*3] |-> strapPinAuxOeN && strapPinPrintOeN && strapPinBootSelectOeN;
   endproperty
   property p_pu; anyRst ##1 anyRst |-> ##[0:1] bootSelectPullUp; endproperty
   property p_rd; rdStrobe && addr == 4'h0 && quiet |=> rdData == {29'h0, $past(snap[2:0])};
   endproperty
   a_fl: assert property (p_fl) else $error("flash select wrong");
   a_dl: assert property (p_dl) else $error("download select wrong");
   a_inv: assert property (p_inv) else $error("invalid flag wrong");
   a_pe: assert property (p_pe) else $error("print enable wrong");
   a_hold: assert property (p_hold) else $error("decode moved");
   a_oe: assert property (p_oe) else $error("pin driven in reset");
   a_pu: assert property (p_pu) else $error("pull-up off in reset");
   a_rd: assert property (p_rd) else $error("strap status wrong");
   c_dl: cover property (quiet && bootDownload);
   c_inv: cover property (quiet && bootInvalid);
   c_np: cover property (quiet && !printEnable);
   c_fl: cover property (quiet && bootFlash && !strapPinBootSelectDriven);
endmodule // strap_latch_boot_select_asserts
bind strap_latch_boot_select strap_latch_boot_select_asserts chk (.clk, .rst_n, .porReset,
   .lpWdtReset, .brownoutReset, .anaWdtReset, .glitchReset, .strapPinAuxIn, .strapPinPrintIn,
   .strapPinBootSelectIn, .strapPinBootSelectDriven, .strapPinAuxOeN, .strapPinPrintOeN,
   .strapPinBootSelectOeN, .bootSelectPullUp, .bootFlash, .bootDownload, .bootInvalid,
   .printEnable, .rdStrobe, .printPolicy, .addr, .rdData);

// File: verification/strap_latch_boot_select_bench.sv
// testbench for the strap latch and boot select block
`timescale 1ns/1ps
`include "strap_latch_consts.vh"
module strap_latch_boot_select_bench;
   reg clk = 1'b0, rst_n = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0, bootDrv = 1'b1;
   reg [4:0] src = 5'h00;
   reg [1:0] printPolicy = 2'h0;
   reg [2:0] lvl = 3'h7, s;
   reg [3:0] addr = 4'h0;
   reg [31:0] wrData = 32'h0;
   wire [31:0] rdData;
   wire strapPinAuxIn, strapPinPrintIn, strapPinBootSelectIn, strapPinBootSelectDriven;
   wire strapPinAuxOut, strapPinPrintOut, strapPinBootSelectOut, bootSelectPullUp;
   wire strapPinAuxOeN, strapPinPrintOeN, strapPinBootSelectOeN;
   integer error_cnt = 0, comparisons = 0, i;
   always #20 clk = ~clk;
   strap_board_model board (.clk, .bootDrv, .strapPinAuxOut, .strapPinPrintOut,
      .strapPinBootSelectOut, .strapPinAuxOeN, .strapPinPrintOeN, .strapPinBootSelectOeN,
      .bootSelectPullUp, .lvl, .strapPinAuxIn, .strapPinPrintIn, .strapPinBootSelectIn,
      .strapPinBootSelectDriven);
   strap_latch_boot_select DUT (.clk, .rst_n, .porReset(src[0]), .lpWdtReset(src[1]),
      .brownoutReset(src[2]), .anaWdtReset(src[3]), .glitchReset(src[4]), .printPolicy,
      .strapPinAuxIn, .strapPinPrintIn, .strapPinBootSelectIn, .strapPinBootSelectDriven,
      .strapPinAuxOut, .strapPinPrintOut, .strapPinBootSelectOut, .strapPinAuxOeN,
      .strapPinPrintOeN, .strapPinBootSelectOeN, .bootSelectPullUp, .bootFlash(),
      .bootDownload(), .bootInvalid(), .printEnable(), .addr, .wrData, .wrStrobe, .rdStrobe,
      .rdData);
   ////////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      begin
         if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk) {addr, wrData, wrStrobe} <= {a, d, 1'b1};
         @(posedge clk) wrStrobe <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         @(posedge clk) {addr, rdStrobe} <= {a, 1'b1};
         @(posedge clk) rdStrobe <= 1'b0;
         #1 comparisons = comparisons + 1;
         if (rdData !== e) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: read %h expected %h", $time, rdData, e);
         end
      end
   endtask
   // expected {print, invalid, download, flash} from straps and policy
   function [3:0] dec(input [2:0] v, input [1:0] p);
      dec = {p == 2'h0 || p == 2'h1 && !v[1] || p == 2'h2 && v[1],
         !(v[0] & (v[2] | v[1])), v[0] & !v[2] & v[1], v[0] & v[2]};
   endfunction
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // every strap pattern, every policy, every reset source; last pass floats boot-select
      for (i = 0; i < 9; i = i + 1) begin
         @(posedge clk) {lvl, printPolicy, bootDrv} <= {i == 8 ? 3'h3 : i[2:0], i[1:0], i != 8};
         s = i == 8 ? 3'h7 : i[2:0];
         @(posedge clk) src <= 5'h01 << (i % 5);
         repeat (4) @(posedge clk);
         src <= 5'h00;
         lvl <= ~lvl;
         repeat (3) @(posedge clk);
         rd(`ADDR_STRAP_STATUS, {29'h0, s});
         rd(`ADDR_BOOT_STATUS, {26'h1, printPolicy, dec(s, printPolicy)});
      end
      wr(`ADDR_PIN_CTRL, 32'h3F);
      repeat (3) @(posedge clk);
      rd(`ADDR_PIN_INPUT, 32'h7);
      wr(`ADDR_STRAP_STATUS, 32'h0);
      rd(`ADDR_STRAP_STATUS, 32'h7);
      rd(4'h2, 32'h0);
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      rd(`ADDR_BOOT_STATUS, 32'h9);
      print_verdict;
   end
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict;
   end
endmodule // strap_latch_boot_select_bench
